// File: include/hs_pkg.sv
// Shared constants, types and register layout of the hot swap control block
package hs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_HS = 8'h00;
	localparam logic [7:0] OFS_MISC = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int HS_INS = 0;
	localparam int HS_EXT = 1;
	localparam int HS_LOO = 2;
	localparam int HS_EIM = 3;
	localparam int HS_LATCH = 4;
	localparam int BOARD_HEALTHY_N_N = 5;
	localparam int MISC_HOLD = 0;
	localparam int MISC_EVEN = 1;
	localparam int OPT_HOLDOFF = 0;
	localparam int OPT_LOAD = 1;
	localparam int OPT_W = 4;
	localparam int IRQ_INS = 0;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_LOAD = 2;
	localparam int IRQ_W = 3;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic MISC_EVEN_RST = 1'b1;
	localparam logic [1:0] SYNC_RST = 2'h1;
	localparam logic [15:0] LOAD_CYCLES = 16'h0040;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {ST_RESET, ST_LOAD, ST_LATCH, ST_HOLD, ST_RUN, ST_EXT} fsm_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} sync_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic [15:0] cnt;
	} load_s;

	typedef struct packed {
		fsm_e fsm;
		logic insertion_flag;
		logic extraction_flag;
		logic led_on_ctrl;
		logic event_line_mask;
		logic holdoff;
		logic ev_en;
		logic [OPT_W-1:0] opts;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic [31:0] rdata;
		logic lrst_n;
		logic lrst_oe;
		logic sw_q;
		logic hl_q;
		logic prst_q;
		logic lrin_q;
		logic load_start;
	} ctl_s;
endpackage

// File: src/hs_sync.sv
// Two-stage synchroniser for the latch switch and healthy inputs
`timescale 1ns/1ps
module hs_sync
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	hs_pkg::sync_s st;
	hs_pkg::sync_s next_st;

	// First stage feeds only the second stage
	always_comb
	begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= {hs_pkg::SYNC_RST, hs_pkg::SYNC_RST};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign dout = st.s2;
endmodule

// File: src/hs_loader.sv
// Serial configuration memory load sequencer, timed by a cycle count
`timescale 1ns/1ps
module hs_loader
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	output logic busy,
	output logic done
);
	hs_pkg::load_s st;
	hs_pkg::load_s next_st;

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (start)
		begin
			next_st.busy = 1'b1;
			next_st.cnt = hs_pkg::LOAD_CYCLES;
		end
		else if (st.busy)
		begin
			next_st.cnt = st.cnt - 16'h0001;
			if (st.cnt == 16'h0001)
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign done = st.done;
endmodule

// File: src/hot_swap_friendly_ctrl.sv
// Hot swap friendly control: latch, healthy, indicator, event line, insertion and extraction
// Contract
// - Drive indicator low when unhealthy or LED bit
// - Latch input low means open, high closed
// - Healthy high or PCI reset holds internal reset
// - PCI reset with healthy low drives local reset
// - Capture option pins on three reset edges
// - Start memory load when leaving internal reset
// - After load set insertion, event, accept config
// - Hold-off option withholds event and retries config
// - Clearing hold-off bit completes the insertion
// - Host write clears insertion and releases event
// - Latch falling edge sets extraction and event
// - Host write clears extraction and event line
// - Latch re-close with LED bit set resumes insertion without reload
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module hot_swap_friendly_ctrl
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic pci_rst_n,
	input wire logic board_healthy_n,
	input wire logic latch_switch_in,
	input wire logic local_reset_in_n,
	input wire logic [hs_pkg::OPT_W-1:0] option_pins,
	input wire hs_pkg::reg_req_s bus,
	output logic [31:0] rdata,
	output logic indicator_led_out,
	output logic indicator_led_oe,
	output logic enum_out,
	output logic enum_oe,
	output logic local_reset_out_n,
	output logic local_reset_oe,
	output logic cfg_accept,
	output logic cfg_retry,
	output logic eeprom_busy,
	output logic irq
);
	hs_pkg::ctl_s st;
	hs_pkg::ctl_s next_st;
	logic [1:0] sync_out;
	logic sw_s;
	logic hl_s;
	logic in_reset;
	logic load_done;

	// ----------------------------------------
	// Input synchronisers and loader
	// ----------------------------------------
	hs_sync u_sync
	(
		.clk(clk),
		.rstn(rstn),
		.din({latch_switch_in, board_healthy_n}),
		.dout(sync_out)
	);

	hs_loader u_loader
	(
		.clk(clk),
		.rstn(rstn),
		.start(st.load_start),
		.busy(eeprom_busy),
		.done(load_done)
	);

	// High means latch closed
	assign sw_s = sync_out[1];
	assign hl_s = sync_out[0];
	assign in_reset = hl_s || !pci_rst_n;

	// ----------------------------------------
	// Register read decode
	// ----------------------------------------
	function automatic logic [31:0] read_word(input logic [7:0] addr, input hs_pkg::ctl_s s,
		input logic sw, input logic hl);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (addr)
			hs_pkg::OFS_HS:
			begin
				w[hs_pkg::HS_INS] = s.insertion_flag;
				w[hs_pkg::HS_EXT] = s.extraction_flag;
				w[hs_pkg::HS_LOO] = s.led_on_ctrl;
				w[hs_pkg::HS_EIM] = s.event_line_mask;
				w[hs_pkg::HS_LATCH] = sw;
				w[hs_pkg::BOARD_HEALTHY_N_N] = hl;
			end
			hs_pkg::OFS_MISC:
			begin
				w[hs_pkg::MISC_HOLD] = s.holdoff;
				w[hs_pkg::MISC_EVEN] = s.ev_en;
				w[8 +: hs_pkg::OPT_W] = s.opts;
			end
			hs_pkg::OFS_IRQ_ST:
			begin
				w[hs_pkg::IRQ_W-1:0] = s.irq_st;
			end
			hs_pkg::OFS_IRQ_EN:
			begin
				w[hs_pkg::IRQ_W-1:0] = s.irq_en;
			end
			default:
			begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.load_start = 1'b0;
		next_st.sw_q = sw_s;
		next_st.hl_q = hl_s;
		next_st.prst_q = pci_rst_n;
		next_st.lrin_q = local_reset_in_n;
		next_st.rdata = 32'h0000_0000;
		if (bus.rd)
		begin
			next_st.rdata = read_word(bus.addr, st, sw_s, hl_s);
		end
		// Straps are taken on healthy fall, PCI reset rise or local reset rise
		if ((st.hl_q && !hl_s) || (!st.prst_q && pci_rst_n) || (!st.lrin_q && local_reset_in_n))
		begin
			next_st.opts = option_pins;
		end
		// Released while healthy is high; low only with PCI reset and a powered back end
		next_st.lrst_oe = !hl_s;
		next_st.lrst_n = pci_rst_n || hl_s;
		if (in_reset)
		begin
			next_st.fsm = hs_pkg::ST_RESET;
			next_st.insertion_flag = 1'b0;
			next_st.extraction_flag = 1'b0;
			next_st.led_on_ctrl = 1'b0;
			next_st.event_line_mask = 1'b0;
			next_st.holdoff = 1'b0;
			next_st.ev_en = hs_pkg::MISC_EVEN_RST;
			next_st.irq_st = '0;
			next_st.irq_en = '0;
		end
		else
		begin
			if (bus.wr)
			begin
				unique case (bus.addr)
					hs_pkg::OFS_HS:
					begin
						if (bus.wdata[hs_pkg::HS_INS] || bus.wdata[hs_pkg::HS_EIM])
						begin
							next_st.insertion_flag = 1'b0;
						end
						if (bus.wdata[hs_pkg::HS_EXT])
						begin
							next_st.extraction_flag = 1'b0;
						end
						next_st.led_on_ctrl = bus.wdata[hs_pkg::HS_LOO];
						next_st.event_line_mask = bus.wdata[hs_pkg::HS_EIM];
					end
					hs_pkg::OFS_MISC:
					begin
						next_st.holdoff = bus.wdata[hs_pkg::MISC_HOLD];
						next_st.ev_en = bus.wdata[hs_pkg::MISC_EVEN];
					end
					hs_pkg::OFS_IRQ_EN:
					begin
						next_st.irq_en = bus.wdata[hs_pkg::IRQ_W-1:0];
					end
					hs_pkg::OFS_IRQ_CLR:
					begin
						next_st.irq_st = st.irq_st & ~bus.wdata[hs_pkg::IRQ_W-1:0];
					end
					default:
					begin
						next_st.irq_st = next_st.irq_st;
					end
				endcase
			end
			// Event sets come after the writes so a set in the clearing cycle wins
			unique case (st.fsm)
				hs_pkg::ST_RESET:
				begin
					next_st.holdoff = next_st.opts[hs_pkg::OPT_HOLDOFF];
					if (next_st.opts[hs_pkg::OPT_LOAD])
					begin
						next_st.load_start = 1'b1;
						next_st.fsm = hs_pkg::ST_LOAD;
					end
					else
					begin
						next_st.fsm = hs_pkg::ST_LATCH;
					end
				end
				hs_pkg::ST_LOAD:
				begin
					if (load_done)
					begin
						next_st.irq_st[hs_pkg::IRQ_LOAD] = 1'b1;
						next_st.fsm = hs_pkg::ST_LATCH;
					end
				end
				hs_pkg::ST_LATCH:
				begin
					if (sw_s && st.holdoff)
					begin
						next_st.fsm = hs_pkg::ST_HOLD;
					end
					else if (sw_s)
					begin
						next_st.insertion_flag = 1'b1;
						next_st.irq_st[hs_pkg::IRQ_INS] = 1'b1;
						next_st.fsm = hs_pkg::ST_RUN;
					end
				end
				hs_pkg::ST_HOLD:
				begin
					if (!st.holdoff)
					begin
						next_st.insertion_flag = 1'b1;
						next_st.irq_st[hs_pkg::IRQ_INS] = 1'b1;
						next_st.fsm = hs_pkg::ST_RUN;
					end
				end
				hs_pkg::ST_RUN:
				begin
					if (st.sw_q && !sw_s)
					begin
						next_st.extraction_flag = 1'b1;
						next_st.irq_st[hs_pkg::IRQ_EXT] = 1'b1;
						next_st.fsm = hs_pkg::ST_EXT;
					end
				end
				hs_pkg::ST_EXT:
				begin
					if (st.sw_q && !sw_s)
					begin
						next_st.extraction_flag = 1'b1;
						next_st.irq_st[hs_pkg::IRQ_EXT] = 1'b1;
					end
					else if (!st.sw_q && sw_s && st.led_on_ctrl)
					begin
						// Back end stayed up, so configuration is still valid
						next_st.fsm = hs_pkg::ST_LATCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = st.rdata;
	assign indicator_led_out = 1'b0;
	assign indicator_led_oe = hl_s || st.led_on_ctrl;
	assign enum_out = 1'b0;
	// Mask gates the line, and writing it set also clears insertion; flags still set underneath
	assign enum_oe = (st.insertion_flag || st.extraction_flag) && st.ev_en && !st.event_line_mask && !hl_s;
	assign local_reset_out_n = st.lrst_n;
	assign local_reset_oe = st.lrst_oe;
	assign cfg_accept = (st.fsm == hs_pkg::ST_RUN) || (st.fsm == hs_pkg::ST_EXT);
	assign cfg_retry = st.fsm == hs_pkg::ST_HOLD;
	assign irq = |(st.irq_st & st.irq_en);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	led_turn_on_a: assert property ($rose(st.led_on_ctrl) |-> indicator_led_oe)
		else $error("indicator not driven after LED bit set");
	ext_edge_a: assert property (st.fsm == hs_pkg::ST_RUN && $fell(sw_s)
		&& !in_reset |=> st.extraction_flag && st.fsm == hs_pkg::ST_EXT)
		else $error("latch opening did not flag extraction");
	single_ext_a: assert property ($rose(st.extraction_flag) |=> !$rose(st.extraction_flag) [*3])
		else $error("extraction flag rose twice for one edge");
	reset_hold_a: assert property (hl_s |=> st.fsm == hs_pkg::ST_RESET
		&& !local_reset_oe && !enum_oe)
		else $error("outputs not released while unhealthy");
	local_reset_a: assert property (!pci_rst_n && !hl_s |=> !local_reset_out_n
		&& local_reset_oe)
		else $error("local reset not driven during PCI reset");
	strap_capture_a: assert property ($rose(pci_rst_n)
		|=> st.opts == $past(option_pins))
		else $error("option pins not captured");
	strap_healthy_a: assert property ($fell(hl_s)
		|=> st.opts == $past(option_pins))
		else $error("option pins not captured on healthy fall");
	strap_local_a: assert property ($rose(local_reset_in_n)
		|=> st.opts == $past(option_pins))
		else $error("option pins not captured on local reset release");
	load_start_a: assert property (st.fsm == hs_pkg::ST_RESET && !in_reset
		&& option_pins[hs_pkg::OPT_LOAD] && $rose(pci_rst_n) |=> ##1 eeprom_busy)
		else $error("load did not start on leaving reset");
	ins_set_a: assert property (st.fsm == hs_pkg::ST_LATCH && sw_s && !st.holdoff
		&& !in_reset |=> st.insertion_flag && cfg_accept)
		else $error("insertion not completed after load");
	holdoff_a: assert property (st.fsm == hs_pkg::ST_HOLD |-> cfg_retry && !st.insertion_flag
		&& !enum_oe)
		else $error("hold-off did not withhold event");
	holdoff_clr_a: assert property (st.fsm == hs_pkg::ST_HOLD && !st.holdoff
		&& !in_reset |=> st.insertion_flag && cfg_accept)
		else $error("clearing hold-off did not complete insertion");
	ins_clear_a: assert property (bus.wr && bus.addr == hs_pkg::OFS_HS
		&& bus.wdata[hs_pkg::HS_INS] && st.fsm == hs_pkg::ST_RUN |=> !st.insertion_flag)
		else $error("insertion flag not cleared by host");
	ext_clear_a: assert property (bus.wr && bus.addr == hs_pkg::OFS_HS
		&& bus.wdata[hs_pkg::HS_EXT] && !$fell(sw_s) |=> !st.extraction_flag)
		else $error("extraction flag not cleared by host");
	resume_a: assert property (st.fsm == hs_pkg::ST_EXT && $rose(sw_s) && st.led_on_ctrl
		&& !in_reset |=> st.fsm == hs_pkg::ST_LATCH && !eeprom_busy)
		else $error("re-closing latch did not resume insertion");
	mask_a: assert property (st.event_line_mask |-> !enum_oe)
		else $error("event line driven while masked");

	insertion_c: cover property (st.fsm == hs_pkg::ST_LOAD ##[1:200] st.insertion_flag);
	extraction_c: cover property (st.fsm == hs_pkg::ST_RUN ##1 st.fsm == hs_pkg::ST_EXT);
	holdoff_c: cover property (st.fsm == hs_pkg::ST_HOLD ##1 st.fsm == hs_pkg::ST_RUN);
	resume_c: cover property (st.fsm == hs_pkg::ST_EXT ##1 st.fsm == hs_pkg::ST_LATCH);
	masked_ext_c: cover property (st.event_line_mask && st.extraction_flag);
endmodule

// File: test/hs_host_model.sv
// Slot and host model: drives the slot pins and resolves the open-drain lines
`timescale 1ns/1ps
module hs_host_model
(
	input wire logic clk,
	input wire logic powered,
	input wire logic in_reset,
	input wire logic closed,
	input wire logic led_out,
	input wire logic led_oe,
	input wire logic enum_out,
	input wire logic enum_oe,
	input wire logic lrst_n,
	input wire logic lrst_oe,
	output logic board_healthy_n,
	output logic pci_rst_n,
	output logic latch_switch_in,
	output logic led_n,
	output logic enum_n,
	output logic local_rst_n
);
	// ----
	// Slot pins
	// ----
	// Start unpowered, in reset, latch open
	logic [2:0] pins = 3'h4;
	always @(posedge clk)
		pins <= {!powered, in_reset ? 1'h0 : 1'h1, closed};
	assign {board_healthy_n, pci_rst_n, latch_switch_in} = pins;
	// ----
	// Pull-ups
	// ----
	// Released lines read high, never the last driven value
	assign led_n = led_oe ? led_out : 1'h1;
	assign enum_n = enum_oe ? enum_out : 1'h1;
	assign local_rst_n = lrst_oe ? lrst_n : 1'h1;
endmodule

// File: test/tb_hot_swap_friendly_ctrl.sv
// Self-checking bench for the hot swap control block
`timescale 1ns/1ps
module tb_hot_swap_friendly_ctrl;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic powered = 1'h0;
	logic in_reset = 1'h1;
	logic closed = 1'h0;
	logic local_reset_in_n = 1'h1;
	logic [hs_pkg::OPT_W-1:0] option_pins = 4'h2;
	hs_pkg::reg_req_s bus = '0;
	logic [31:0] rdata;
	logic [31:0] rd_val;
	logic led_out, led_oe, enum_out, enum_oe, lrst_n, lrst_oe;
	logic cfg_accept, cfg_retry, eeprom_busy, irq;
	logic board_healthy_n, pci_rst_n, latch_switch_in, led_n, enum_n, local_rst_n;
	int errors = 0;
	int comparisons = 0;

	always #5 clk = ~clk;

	hot_swap_friendly_ctrl uut
	(
		.clk(clk), .rstn(rstn), .pci_rst_n(pci_rst_n), .board_healthy_n(board_healthy_n),
		.latch_switch_in(latch_switch_in), .local_reset_in_n(local_reset_in_n),
		.option_pins(option_pins), .bus(bus), .rdata(rdata),
		.indicator_led_out(led_out), .indicator_led_oe(led_oe),
		.enum_out(enum_out), .enum_oe(enum_oe),
		.local_reset_out_n(lrst_n), .local_reset_oe(lrst_oe),
		.cfg_accept(cfg_accept), .cfg_retry(cfg_retry), .eeprom_busy(eeprom_busy), .irq(irq)
	);

	hs_host_model host
	(
		.clk(clk), .powered(powered), .in_reset(in_reset), .closed(closed),
		.led_out(led_out), .led_oe(led_oe), .enum_out(enum_out), .enum_oe(enum_oe),
		.lrst_n(lrst_n), .lrst_oe(lrst_oe), .board_healthy_n(board_healthy_n),
		.pci_rst_n(pci_rst_n), .latch_switch_in(latch_switch_in), .led_n(led_n),
		.enum_n(enum_n), .local_rst_n(local_rst_n)
	);

	// ----
	// Shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		bus.wr <= 1'h0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		bus.rd <= 1'h0;
		#1;
		rd_val = rdata;
	endtask

	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_power_up;
		cycles(4);
		check(led_n, 1'h0);
		check({lrst_oe, enum_oe, cfg_accept}, 3'h0);
		powered <= 1'h1;
		cycles(6);
		check({lrst_oe, local_rst_n}, 2'h2);
		check(led_n, 1'h1);
	endtask

	task automatic t_insert;
		closed <= 1'h1;
		in_reset <= 1'h0;
		for (int i = 0; i < 10 && eeprom_busy !== 1'h1; i++) @(posedge clk);
		#1;
		check(eeprom_busy, 1'h1);
		check(local_rst_n, 1'h1);
		for (int i = 0; i < 100 && cfg_accept !== 1'h1; i++) @(posedge clk);
		#1;
		check({cfg_accept, enum_n}, 2'h2);
		bus_rd(hs_pkg::OFS_HS);
		check(rd_val[5:0], 6'h11);
		bus_rd(hs_pkg::OFS_MISC);
		check({rd_val[11:8], rd_val[1:0]}, 6'h0A);
		bus_rd(8'h20);
		check(rd_val, 32'h0);
	endtask

	task automatic t_clear_ins;
		bus_wr(hs_pkg::OFS_IRQ_EN, 32'h7);
		check(irq, 1'h1);
		bus_wr(hs_pkg::OFS_IRQ_CLR, 32'h7);
		check(irq, 1'h0);
		bus_rd(hs_pkg::OFS_IRQ_ST);
		check(rd_val, 32'h0);
		bus_wr(hs_pkg::OFS_HS, 32'h1);
		check(enum_n, 1'h1);
		bus_rd(hs_pkg::OFS_HS);
		check(rd_val[0], 1'h0);
	endtask

	task automatic t_extract;
		closed <= 1'h0;
		cycles(6);
		check({enum_n, irq}, 2'h1);
		bus_rd(hs_pkg::OFS_HS);
		check(rd_val[1:0], 2'h2);
		bus_wr(hs_pkg::OFS_HS, 32'h2);
		check(enum_n, 1'h1);
		cycles(4);
		bus_rd(hs_pkg::OFS_HS);
		check(rd_val[1], 1'h0);
		bus_wr(hs_pkg::OFS_IRQ_CLR, 32'h7);
		// The card is idle here, so the indicator may be lit
		bus_wr(hs_pkg::OFS_HS, 32'h4);
		check(led_n, 1'h0);
		closed <= 1'h1;
		repeat (6)
		begin
			cycles(1);
			check(eeprom_busy, 1'h0);
		end
		check(enum_n, 1'h0);
		bus_wr(hs_pkg::OFS_HS, 32'h1);
		check({led_n, enum_n}, 2'h3);
	endtask

	task automatic t_mask;
		bus_wr(hs_pkg::OFS_HS, 32'h8);
		closed <= 1'h0;
		cycles(6);
		check(enum_oe, 1'h0);
		bus_rd(hs_pkg::OFS_HS);
		check(rd_val[1], 1'h1);
		bus_wr(hs_pkg::OFS_HS, 32'h2);
	endtask

	task automatic t_holdoff;
		option_pins <= 4'h1;
		powered <= 1'h0;
		cycles(5);
		check({led_n, lrst_oe, enum_oe}, 3'h0);
		powered <= 1'h1;
		closed <= 1'h1;
		for (int i = 0; i < 30 && cfg_retry !== 1'h1; i++) @(posedge clk);
		cycles(2);
		check({cfg_retry, cfg_accept, enum_n}, 3'h5);
		bus_rd(hs_pkg::OFS_MISC);
		check({rd_val[11:8], rd_val[0]}, 5'h03);
		// Local processor has finished programming
		bus_wr(hs_pkg::OFS_MISC, 32'h2);
		cycles(2);
		check({cfg_accept, enum_n}, 2'h2);
	endtask

	// Straps are taken again when the local bus leaves reset
	task automatic t_local_reset;
		@(posedge clk);
		option_pins <= 4'hC;
		local_reset_in_n <= 1'h0;
		@(posedge clk);
		local_reset_in_n <= 1'h1;
		cycles(2);
		bus_rd(hs_pkg::OFS_MISC);
		check(rd_val[11:8], 4'hC);
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		t_power_up();
		t_insert();
		t_clear_ins();
		t_extract();
		t_mask();
		t_holdoff();
		t_local_reset();
		complete_run();
	end

	// About sixty times the expected run
	initial
	begin
		#100000;
		errors++;
		complete_run();
	end
endmodule
